// ===== verilog/exec_pkg.sv
// Contract
// - Opcode 0D forces the carry flag to one in two cycles, OP then OP+1.
// - Opcode 0F forces the interrupt mask flag to one in two cycles.
// - With the mask flag set only non-maskable requests are accepted.
// - Opcode 0B forces the overflow flag to one in two cycles.
// - A byte store writes accumulator A or B to memory, unchanged.
// - A byte store sets N from bit 7, Z on zero and clears V.
// - Byte stores are 97 B7 A7 18A7 for A and D7 F7 E7 18E7 for B.
// - Bus sequences follow the mode: 00dd, hh then ll, idle FFFF, Y prefix.
// - The double store writes A at the address and B at the next one.
// - Double stores take 4, 5, 5 and 6 cycles, low write right after high.
`default_nettype none
package exec_pkg;
	localparam logic [7:0] OP_SET_CARRY = 8'h0d;
	localparam logic [7:0] OP_SET_MASK  = 8'h0f;
	localparam logic [7:0] OP_SET_OVF   = 8'h0b;
	localparam logic [7:0] OP_PREFIX_Y  = 8'h18;
	localparam logic [7:0] OP_STA_DIR   = 8'h97;
	localparam logic [7:0] OP_STA_EXT   = 8'hb7;
	localparam logic [7:0] OP_STA_IDX   = 8'ha7;
	localparam logic [7:0] OP_STB_DIR   = 8'hd7;
	localparam logic [7:0] OP_STB_EXT   = 8'hf7;
	localparam logic [7:0] OP_STB_IDX   = 8'he7;
	localparam logic [7:0] OP_STD_DIR   = 8'hdd;
	localparam logic [7:0] OP_STD_EXT   = 8'hfd;
	localparam logic [7:0] OP_STD_IDX   = 8'hed;
	localparam logic [15:0] IDLE_ADDR   = 16'hffff;
	localparam logic [7:0] DIRECT_PAGE  = 8'h00;
	// Bit positions inside condition_flags.
	localparam int FLAG_C = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;
	localparam int FLAG_I = 4;
	// Register offsets on the bus, byte addresses.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC     = 8'h08;
	localparam logic [7:0] REG_ACC    = 8'h0c;
	localparam logic [7:0] REG_INDEX  = 8'h10;
	localparam logic [7:0] REG_FLAGS  = 8'h14;
	localparam int CTRL_RUN       = 0;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_ILLEGAL   = 1;
	localparam logic [7:0] FLAGS_RESET = 8'h10;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [2:0] HSIZE_WORD  = 3'b010;
	typedef enum logic [2:0] {
		KIND_NONE, KIND_SET_C, KIND_SET_I, KIND_SET_V, KIND_STORE
	} kind_t;
	typedef enum logic [1:0] {MODE_DIR, MODE_EXT, MODE_IDX} mode_t;
endpackage : exec_pkg
`default_nettype wire

// ===== verilog/exec_if.sv
`default_nettype none
// Decode and flag results shared between the core and its helpers.
interface exec_if;
	import exec_pkg::*;
	logic [7:0]  opcode;
	logic        prefixed;
	logic        legal;
	kind_t       kind;
	mode_t       mode;
	logic        use_b;
	logic        dbl;
	logic [7:0]  flags_in;
	logic [15:0] value;
	logic [7:0]  flags_out;
	modport dec (input opcode, prefixed,
		output legal, kind, mode, use_b, dbl);
	modport flg (input kind, dbl, flags_in, value, output flags_out);
	modport core (output opcode, prefixed, flags_in, value,
		input legal, kind, mode, use_b, dbl, flags_out);
endinterface : exec_if
`default_nettype wire

// ===== verilog/exec_decoder.sv
`default_nettype none
module exec_decoder (
	exec_if.dec d
);
	import exec_pkg::*;
	// One table serves both the fetch decision and the later cycles.
	always_comb begin
		d.legal = 1'b1;
		d.kind  = KIND_STORE;
		d.mode  = MODE_IDX;
		d.use_b = 1'b0;
		d.dbl   = 1'b0;
		if (d.prefixed) begin
			case (d.opcode)
				OP_STA_IDX: d.use_b = 1'b0;
				OP_STB_IDX: d.use_b = 1'b1;
				OP_STD_IDX: d.dbl = 1'b1;
				default: begin
					d.legal = 1'b0;
					d.kind  = KIND_NONE;
				end
			endcase
		end else begin
			case (d.opcode)
				OP_SET_CARRY: d.kind = KIND_SET_C;
				OP_SET_MASK:  d.kind = KIND_SET_I;
				OP_SET_OVF:   d.kind = KIND_SET_V;
				OP_STA_DIR:   d.mode = MODE_DIR;
				OP_STA_EXT:   d.mode = MODE_EXT;
				OP_STA_IDX:   d.mode = MODE_IDX;
				OP_STB_DIR: begin
					d.mode  = MODE_DIR;
					d.use_b = 1'b1;
				end
				OP_STB_EXT: begin
					d.mode  = MODE_EXT;
					d.use_b = 1'b1;
				end
				OP_STB_IDX:   d.use_b = 1'b1;
				OP_STD_DIR: begin
					d.mode = MODE_DIR;
					d.dbl  = 1'b1;
				end
				OP_STD_EXT: begin
					d.mode = MODE_EXT;
					d.dbl  = 1'b1;
				end
				OP_STD_IDX:   d.dbl = 1'b1;
				default: begin
					d.legal = 1'b0;
					d.kind  = KIND_NONE;
				end
			endcase
		end
	end
endmodule : exec_decoder
`default_nettype wire

// ===== verilog/exec_flags.sv
`default_nettype none
module exec_flags (
	exec_if.flg f
);
	import exec_pkg::*;
	// Next condition_flags; S, X and H are never touched here.
	always_comb begin
		f.flags_out = f.flags_in;
		case (f.kind)
			KIND_SET_C: f.flags_out[FLAG_C] = 1'b1;
			KIND_SET_I: f.flags_out[FLAG_I] = 1'b1;
			KIND_SET_V: f.flags_out[FLAG_V] = 1'b1;
			KIND_STORE: begin
				if (f.dbl) begin
					f.flags_out[FLAG_N] = f.value[15];
					f.flags_out[FLAG_Z] = (f.value == 16'h0000);
				end else begin
					f.flags_out[FLAG_N] = f.value[7];
					f.flags_out[FLAG_Z] = (f.value[7:0] == 8'h00);
				end
				f.flags_out[FLAG_V] = 1'b0;
			end
			default: f.flags_out = f.flags_in;
		endcase
	end
endmodule : exec_flags
`default_nettype wire

// ===== verilog/flag_set_and_store_exec.sv
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`default_nettype none
module flag_set_and_store_exec (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             mem_rw,
	input  wire logic [7:0]  mem_rdata,
	output logic             cycle_active,
	input  wire logic        irq_req,
	input  wire logic        nmi_req,
	output logic             int_accept,
	output logic             int_nonmaskable
);
	import exec_pkg::*;

	typedef enum logic [3:0] {
		S_HALT, S_FETCH, S_PREFIX, S_INH, S_OPR1, S_OPR2, S_IDLE,
		S_WR_HI, S_WR_LO
	} state_t;

	state_t      state_reg;
	state_t      state_next;
	logic [15:0] pc_reg;
	logic [15:0] ea_reg;
	logic [7:0]  opcode_reg;
	logic        prefix_reg;
	logic [7:0]  condition_flags_reg;
	logic [7:0]  accumulator_first_reg;
	logic [7:0]  accumulator_second_reg;
	logic [15:0] index_x_reg;
	logic [15:0] index_y_reg;
	logic        run_reg;
	logic        illegal_reg;
	logic        dp_wr_reg;
	logic        dp_rd_reg;
	logic        rd_done_reg;
	logic [7:0]  dp_addr_reg;
	logic [31:0] hrdata_reg;
	logic        ap_take;
	logic        bus_we;
	logic        core_idle;
	logic        illegal_hit;
	logic        flags_done;
	logic        boundary_run;
	logic [7:0]  selected_accumulator;
	logic [15:0] double_accumulator;

	exec_if ei ();

	exec_decoder u_dec (
		.d (ei)
	);

	exec_flags u_flg (
		.f (ei)
	);

	// Register read mux; unmapped offsets read as zero.
	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			REG_CTRL:   r[CTRL_RUN] = run_reg;
			REG_STATUS: begin
				r[STAT_BUSY]    = (state_reg != S_HALT);
				r[STAT_ILLEGAL] = illegal_reg;
			end
			REG_PC:     r[15:0] = pc_reg;
			REG_ACC:    r[15:0] = double_accumulator;
			REG_INDEX:  r = {index_y_reg, index_x_reg};
			REG_FLAGS:  r[7:0] = condition_flags_reg;
			default:    r = 32'h0000_0000;
		endcase
		return r;
	endfunction : reg_read

	// Bus slave: writes finish with no wait, reads take one wait state
	// so that a read right after a write always sees the new value.
	assign ap_take   = hsel & htrans[1] & hready;
	assign hreadyout = ~(dp_rd_reg & ~rd_done_reg);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign bus_we    = dp_wr_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dp_wr_reg   <= 1'b0;
			dp_rd_reg   <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else if (ap_take) begin
			dp_wr_reg   <= hwrite & (hsize == HSIZE_WORD);
			dp_rd_reg   <= ~hwrite;
			dp_addr_reg <= haddr[7:0];
		end else if (hreadyout) begin
			dp_wr_reg <= 1'b0;
			dp_rd_reg <= 1'b0;
		end
	end

	// Read data is captured in the wait cycle and held until the next one.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_done_reg <= 1'b0;
			hrdata_reg  <= 32'h0000_0000;
		end else if (dp_rd_reg & ~rd_done_reg) begin
			rd_done_reg <= 1'b1;
			hrdata_reg  <= reg_read(dp_addr_reg);
		end else begin
			rd_done_reg <= 1'b0;
		end
	end

	assign core_idle = (state_reg == S_HALT);

	// Run bit: software sets it, an unknown opcode drops it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_reg <= 1'b0;
		end else if (illegal_hit) begin
			run_reg <= 1'b0;
		end else if (bus_we && dp_addr_reg == REG_CTRL) begin
			run_reg <= hwdata[CTRL_RUN];
		end
	end

	// Sticky illegal flag, write one to clear; a new hit wins.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			illegal_reg <= 1'b0;
		end else if (illegal_hit) begin
			illegal_reg <= 1'b1;
		end else if (bus_we && dp_addr_reg == REG_STATUS &&
			hwdata[STAT_ILLEGAL]) begin
			illegal_reg <= 1'b0;
		end
	end

	// Accumulators and index registers are loaded only while halted,
	// which keeps them out of reach of a running instruction.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			accumulator_first_reg  <= 8'h00;
			accumulator_second_reg <= 8'h00;
			index_x_reg            <= 16'h0000;
			index_y_reg            <= 16'h0000;
		end else if (bus_we && core_idle) begin
			if (dp_addr_reg == REG_ACC) begin
				accumulator_first_reg  <= hwdata[15:8];
				accumulator_second_reg <= hwdata[7:0];
			end
			if (dp_addr_reg == REG_INDEX) begin
				index_x_reg <= hwdata[15:0];
				index_y_reg <= hwdata[31:16];
			end
		end
	end

	assign double_accumulator = {accumulator_first_reg,
		accumulator_second_reg};
	assign selected_accumulator = ei.use_b ? accumulator_second_reg :
		accumulator_first_reg;

	// Decode the byte on the bus during fetches, the held opcode after.
	assign ei.opcode   = (state_reg == S_FETCH || state_reg == S_PREFIX) ?
		mem_rdata : opcode_reg;
	assign ei.prefixed = (state_reg == S_FETCH) ? 1'b0 : prefix_reg;
	assign ei.flags_in = condition_flags_reg;
	assign ei.value    = ei.dbl ? double_accumulator :
		{8'h00, selected_accumulator};

	assign boundary_run = run_reg;
	assign illegal_hit  = ((state_reg == S_FETCH &&
		mem_rdata != OP_PREFIX_Y) || state_reg == S_PREFIX) && !ei.legal;

	// Instruction sequencer, one bus cycle per clock.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_HALT: state_next = run_reg ? S_FETCH : S_HALT;
			S_FETCH: begin
				if (mem_rdata == OP_PREFIX_Y) begin
					state_next = S_PREFIX;
				end else if (!ei.legal) begin
					state_next = S_HALT;
				end else if (ei.kind == KIND_STORE) begin
					state_next = S_OPR1;
				end else begin
					state_next = S_INH;
				end
			end
			S_PREFIX: state_next = ei.legal ? S_OPR1 : S_HALT;
			S_INH: state_next = boundary_run ? S_FETCH : S_HALT;
			S_OPR1: begin
				case (ei.mode)
					MODE_DIR: state_next = S_WR_HI;
					MODE_EXT: state_next = S_OPR2;
					default:  state_next = S_IDLE;
				endcase
			end
			S_OPR2:  state_next = S_WR_HI;
			S_IDLE:  state_next = S_WR_HI;
			S_WR_HI: begin
				if (ei.dbl) begin
					state_next = S_WR_LO;
				end else begin
					state_next = boundary_run ? S_FETCH : S_HALT;
				end
			end
			S_WR_LO: state_next = boundary_run ? S_FETCH : S_HALT;
			default: state_next = S_HALT;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= S_HALT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Program counter steps past every byte fetched from the stream.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pc_reg <= PC_RESET;
		end else if (core_idle) begin
			if (bus_we && dp_addr_reg == REG_PC) begin
				pc_reg <= hwdata[15:0];
			end
		end else if (state_reg == S_FETCH || state_reg == S_PREFIX ||
			state_reg == S_OPR1 || state_reg == S_OPR2) begin
			pc_reg <= pc_reg + 16'h0001;
		end
	end

	// Held opcode and prefix marker for the cycles after the fetch.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			opcode_reg <= 8'h00;
			prefix_reg <= 1'b0;
		end else if (state_reg == S_FETCH) begin
			opcode_reg <= mem_rdata;
			prefix_reg <= (mem_rdata == OP_PREFIX_Y);
		end else if (state_reg == S_PREFIX) begin
			opcode_reg <= mem_rdata;
		end
	end

	// Effective address build-up; stepped by one for the second write.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ea_reg <= 16'h0000;
		end else begin
			case (state_reg)
				S_OPR1: begin
					case (ei.mode)
						MODE_DIR: ea_reg <= {DIRECT_PAGE, mem_rdata};
						MODE_EXT: ea_reg <= {mem_rdata, 8'h00};
						default:  ea_reg <= (prefix_reg ? index_y_reg :
							index_x_reg) + {8'h00, mem_rdata};
					endcase
				end
				S_OPR2:  ea_reg <= {ea_reg[15:8], mem_rdata};
				S_WR_HI: ea_reg <= ea_reg + 16'h0001;
				default: ea_reg <= ea_reg;
			endcase
		end
	end

	assign flags_done = (state_reg == S_INH) ||
		(state_reg == S_WR_HI && !ei.dbl) || (state_reg == S_WR_LO);

	// While running, flags change only at the last cycle of an instruction.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			condition_flags_reg <= FLAGS_RESET;
		end else if (flags_done) begin
			condition_flags_reg <= ei.flags_out;
		end else if (core_idle && bus_we && dp_addr_reg == REG_FLAGS) begin
			condition_flags_reg <= hwdata[7:0];
		end
	end

	// Bus drive; write cycles pull read/write low.
	always_comb begin
		mem_addr  = pc_reg;
		mem_wdata = 8'h00;
		mem_rw    = 1'b1;
		case (state_reg)
			S_IDLE: mem_addr = IDLE_ADDR;
			S_WR_HI: begin
				mem_addr  = ea_reg;
				mem_wdata = ei.dbl ? accumulator_first_reg :
					selected_accumulator;
				mem_rw    = 1'b0;
			end
			S_WR_LO: begin
				mem_addr  = ea_reg;
				mem_wdata = accumulator_second_reg;
				mem_rw    = 1'b0;
			end
			default: mem_addr = pc_reg;
		endcase
	end

	assign cycle_active = ~core_idle;

	// Requests are seen only at an opcode fetch, an instruction boundary.
	// mask gates maskable requests only
	assign int_accept = (state_reg == S_FETCH) &
		(nmi_req | (irq_req & ~condition_flags_reg[FLAG_I]));
	assign int_nonmaskable = (state_reg == S_FETCH) & nmi_req;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_carry_set: assert property (
		state_reg == S_INH && opcode_reg == OP_SET_CARRY |=>
		condition_flags_reg[FLAG_C] &&
		condition_flags_reg[7:1] == $past(condition_flags_reg[7:1]))
		else $error("carry not set alone");
	a_mask_set: assert property (
		state_reg == S_FETCH && mem_rdata == OP_SET_MASK |=>
		state_reg == S_INH ##1 condition_flags_reg[FLAG_I] &&
		(condition_flags_reg & 8'hef) ==
		($past(condition_flags_reg, 2) & 8'hef))
		else $error("mask not set in two cycles");
	a_irq_masked: assert property (
		condition_flags_reg[FLAG_I] && !nmi_req |-> !int_accept)
		else $error("maskable request accepted while masked");
	a_ovf_set: assert property (
		state_reg == S_INH && opcode_reg == OP_SET_OVF |=>
		condition_flags_reg[FLAG_V] && $stable(condition_flags_reg[FLAG_C]))
		else $error("overflow not set");
	a_store_data: assert property (
		state_reg == S_WR_HI && !ei.dbl |->
		!mem_rw && mem_wdata == selected_accumulator ##1
		$stable(double_accumulator))
		else $error("byte store data wrong");
	a_byte_flags: assert property (
		state_reg == S_WR_HI && !ei.dbl |=>
		condition_flags_reg[FLAG_N] == $past(mem_wdata[7]) &&
		condition_flags_reg[FLAG_Z] == ($past(mem_wdata) == 8'h00) &&
		!condition_flags_reg[FLAG_V])
		else $error("byte store flags wrong");
	a_direct_addr: assert property (
		state_reg == S_OPR1 && ei.mode == MODE_DIR |=>
		mem_addr == {DIRECT_PAGE, $past(mem_rdata)} && !mem_rw)
		else $error("direct write address wrong");
	a_idle_read: assert property (
		state_reg == S_OPR1 && ei.mode == MODE_IDX |=>
		mem_addr == IDLE_ADDR && mem_rw ##1 !mem_rw)
		else $error("indexed idle read missing");
	a_double_pair: assert property (
		state_reg == S_WR_HI && ei.dbl |->
		mem_wdata == accumulator_first_reg ##1
		!mem_rw && mem_addr == $past(mem_addr) + 16'h0001 &&
		mem_wdata == accumulator_second_reg)
		else $error("double store pair wrong");
	a_double_len: assert property (
		state_reg == S_FETCH && mem_rdata == OP_STD_DIR |=>
		state_reg == S_OPR1 ##1 state_reg == S_WR_HI ##1
		state_reg == S_WR_LO ##1 state_reg != S_WR_LO)
		else $error("double direct store length wrong");
	a_double_flags: assert property (
		state_reg == S_WR_LO |=>
		condition_flags_reg[FLAG_Z] == ($past(double_accumulator) == 16'h0)
		&& condition_flags_reg[FLAG_N] == $past(accumulator_first_reg[7])
		&& !condition_flags_reg[FLAG_V])
		else $error("double store flags wrong");

	c_y_double: cover property (
		state_reg == S_PREFIX && mem_rdata == OP_STD_IDX ##4
		state_reg == S_WR_LO);
	c_ext_byte: cover property (
		state_reg == S_OPR2 ##1 state_reg == S_WR_HI);
	c_irq_taken: cover property (int_accept && !nmi_req);
	c_illegal: cover property (illegal_hit);
endmodule : flag_set_and_store_exec
`default_nettype wire

// ===== test/cpu_mem_model.sv
`default_nettype none
// Byte-wide memory on the CPU bus; it also logs every active cycle and every write.
module cpu_mem_model (
	input  wire logic        clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic [7:0]  mem_wdata,
	input  wire logic        mem_rw,
	output logic [7:0]       mem_rdata,
	input  wire logic        cycle_active,
	input  wire logic        int_accept,
	input  wire logic        int_nonmaskable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [0:65535];
	logic [18:0] trace [$];
	logic [23:0] wlog [$];
	// Reads answer in the same cycle; in a write cycle the line is not
	// ours, so it shows the inverted byte instead of a stale read value.
	assign mem_rdata = mem_rw ? mem[mem_addr] : ~mem_wdata;
	// Sampled at the edge that ends each cycle, before the core moves on.
	always @(posedge clk) begin
		if (cycle_active) begin
			trace.push_back({int_nonmaskable, int_accept, mem_rw, mem_addr});
			if (!mem_rw) begin
				mem[mem_addr] <= mem_wdata;
				wlog.push_back({mem_addr, mem_wdata});
			end
		end
	end
endmodule : cpu_mem_model
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import exec_pkg::*;
	logic        clk;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        mem_rw;
	logic [7:0]  mem_rdata;
	logic        cycle_active;
	logic        irq_req;
	logic        nmi_req;
	logic        int_accept;
	logic        int_nonmaskable;
	int          n_errors;
	int          cmp_count;
	logic [31:0] rd;

	// The single slave drives the bus ready, so hready is its own hreadyout.
	flag_set_and_store_exec dut_u (.clk(clk), .arst_n(arst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rw(mem_rw), .mem_rdata(mem_rdata),
		.cycle_active(cycle_active), .irq_req(irq_req), .nmi_req(nmi_req),
		.int_accept(int_accept), .int_nonmaskable(int_nonmaskable));

	cpu_mem_model mem_u (.clk(clk), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rw(mem_rw), .mem_rdata(mem_rdata),
		.cycle_active(cycle_active), .int_accept(int_accept),
		.int_nonmaskable(int_nonmaskable));

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Value seen at negedge is what the next rising edge samples.
	task automatic wait_rdy(output logic [31:0] d);
		logic r;
		int   n;
		n = 0;
		do begin
			@(negedge clk);
			r = hreadyout;
			d = hrdata;
			@(posedge clk);
			n++;
		end while (r !== 1'b1 && n < 20);
		if (r !== 1'b1) begin
			n_errors++;
			$display("unexpected hready: expected 1 seen %b", r);
			summarize();
		end
	endtask : wait_rdy

	// One single word transfer, entered just after a rising edge.
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= HSIZE_WORD;
		wait_rdy(d);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(d);
	endtask : ahb

	// Loads a program, sets up the core while halted, runs it to the
	// closing illegal opcode and clears the sticky status bit.
	task automatic run_prog(input logic [15:0] pc, input logic [7:0] p [$],
		input logic [31:0] acc, input logic [7:0] fl);
		int n;
		foreach (p[i]) begin
			mem_u.mem[pc + 16'(i)] = p[i];
		end
		mem_u.trace.delete();
		mem_u.wlog.delete();
		ahb(1'b1, REG_PC, {16'h0, pc}, rd);
		ahb(1'b1, REG_ACC, acc, rd);
		ahb(1'b1, REG_INDEX, 32'h3000_2000, rd);
		ahb(1'b1, REG_FLAGS, {24'h0, fl}, rd);
		ahb(1'b1, REG_CTRL, 32'h1, rd);
		n = 0;
		do begin
			ahb(1'b0, REG_STATUS, 32'h0, rd);
			n++;
		end while (rd[STAT_BUSY] !== 1'b0 && n < 200);
		chk("busy", 0, rd[STAT_BUSY]);
		chk("illegal", 1, rd[STAT_ILLEGAL]);
		ahb(1'b1, REG_STATUS, 32'h2, rd);
		ahb(1'b0, REG_STATUS, 32'h0, rd);
		chk("illegal cleared", 0, rd[STAT_ILLEGAL]);
	endtask : run_prog

	task automatic chk_writes(input logic [23:0] e [8]);
		chk("write count", 8, mem_u.wlog.size());
		foreach (e[i]) begin
			chk("write", e[i], mem_u.wlog[i]);
		end
	endtask : chk_writes

	task automatic chk_reg(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		ahb(1'b0, a, 32'h0, rd);
		chk(what, exp, rd);
	endtask : chk_reg

	task automatic t_reset();
		chk("mem_rw", 1, mem_rw);
		chk("cycle_active", 0, cycle_active);
		chk("int_accept", 0, int_accept);
		chk("hresp", 0, hresp);
		chk_reg("flags", REG_FLAGS, {24'h0, FLAGS_RESET});
		chk_reg("unmapped", 8'h40, 32'h0);
		$display("test reset done");
	endtask : t_reset

	// Each inherent set takes two reads; the last fetch sees the mask.
	task automatic t_flag_set();
		irq_req <= 1'b1;
		run_prog(16'h0100, '{OP_SET_CARRY, OP_SET_OVF, OP_SET_MASK, 8'h00},
			32'h0, 8'h00);
		irq_req <= 1'b0;
		chk_reg("flags", REG_FLAGS, 32'h13);
		chk("cycles", 7, mem_u.trace.size());
		for (int i = 0; i < 7; i++) begin
			chk("addr", 32'h0100 + (i + 1) / 2, mem_u.trace[i][15:0]);
			chk("rw", 1, mem_u.trace[i][16]);
		end
		chk("irq taken", 1, mem_u.trace[4][17]);
		chk("irq masked", 0, mem_u.trace[6][17]);
		chk("nmi idle", 0, mem_u.trace[4][18]);
		$display("test flag_set done");
	endtask : t_flag_set

	// All eight byte stores; B holds zero so the last one sets Z.
	// A prefix followed by an unknown byte stops the run at the end.
	task automatic t_byte_store();
		logic [23:0] e [8] = '{24'h004080, 24'h123480, 24'h200580,
			24'h300680, 24'h004100, 24'h123500, 24'h200700, 24'h300800};
		int idle;
		run_prog(16'h0200, '{OP_STA_DIR, 8'h40, OP_STA_EXT, 8'h12, 8'h34,
			OP_STA_IDX, 8'h05, OP_PREFIX_Y, OP_STA_IDX, 8'h06,
			OP_STB_DIR, 8'h41, OP_STB_EXT, 8'h12, 8'h35, OP_STB_IDX,
			8'h07, OP_PREFIX_Y, OP_STB_IDX, 8'h08, OP_PREFIX_Y, 8'h00},
			32'h8000, 8'h09);
		chk_writes(e);
		chk_reg("flags", REG_FLAGS, 32'h05);
		chk_reg("acc", REG_ACC, 32'h8000);
		chk("cycles", 34, mem_u.trace.size());
		idle = 0;
		foreach (mem_u.trace[i]) begin
			if (mem_u.trace[i][16:0] === 17'h1ffff) begin
				idle++;
			end
		end
		chk("idle reads", 4, idle);
		$display("test byte_store done");
	endtask : t_byte_store

	// Double stores: high byte then low byte in back-to-back writes.
	task automatic t_double();
		logic [23:0] e [8] = '{24'h005080, 24'h005100, 24'h123680,
			24'h123700, 24'h200980, 24'h200a00, 24'h300a80, 24'h300b00};
		logic [20:0] rdm;
		rdm = ~21'h0c318c;
		nmi_req <= 1'b1;
		run_prog(16'h0300, '{OP_STD_DIR, 8'h50, OP_STD_EXT, 8'h12, 8'h36,
			OP_STD_IDX, 8'h09, OP_PREFIX_Y, OP_STD_IDX, 8'h0a, 8'h00},
			32'h8000, 8'h13);
		nmi_req <= 1'b0;
		chk_writes(e);
		chk_reg("flags", REG_FLAGS, 32'h19);
		chk_reg("acc", REG_ACC, 32'h8000);
		chk("cycles", 21, mem_u.trace.size());
		for (int i = 0; i < 21; i++) begin
			chk("rw", rdm[i], mem_u.trace[i][16]);
		end
		chk("nmi taken", 3, mem_u.trace[0][18:17]);
		$display("test double done");
	endtask : t_double

	// Reset is held for six cycles, then the scenarios run in order.
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		irq_req = 1'b0;
		nmi_req = 1'b0;
		n_errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_flag_set();
		t_byte_store();
		t_double();
		summarize();
	end
endmodule : tb
`default_nettype wire
